//--- pmrs_pkg.sv
// constants, register map and state codes of the power mode and reset sequencer
package pmrs_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PWRUP_T0_US = 140;
  localparam int PWRUP_T1_US = 4500;
  localparam int PWRUP_T2_US = 18000;
  localparam int PWRUP_T3_US = 72000;
  localparam int PWRUP_T4_US = 288000;
  localparam int TMR_W = 26;
  localparam int AXI_AW = 8;
  localparam int SYNC_W = 11;

  function automatic logic [25:0] us_to_cyc(input int t_us);
    return 26'((t_us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  localparam logic [25:0] PWRUP_CYC_0 = us_to_cyc(PWRUP_T0_US);
  localparam logic [25:0] PWRUP_CYC_1 = us_to_cyc(PWRUP_T1_US);
  localparam logic [25:0] PWRUP_CYC_2 = us_to_cyc(PWRUP_T2_US);
  localparam logic [25:0] PWRUP_CYC_3 = us_to_cyc(PWRUP_T3_US);
  localparam logic [25:0] PWRUP_CYC_4 = us_to_cyc(PWRUP_T4_US);
  localparam logic [25:0] OST_SHORT_CYC = 26'h000_0001;
  localparam logic [25:0] OST_LONG_CYC = 26'h000_0010;
  localparam logic [25:0] WAKE_XTAL_CYC = 26'h000_0200;
  localparam logic [25:0] WAKE_RC_CYC = 26'h000_0010;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CFG = 8'h0C;

  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CMD_HALT_BIT = 0;
  localparam int CMD_KICK_BIT = 1;
  localparam int CFG_XTAL_BIT = 3;
  localparam int CFG_FAST_BIT = 4;
  localparam logic [4:0] CFG_RST = 5'h10;

  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_HALT = 2'h1;
  localparam logic [1:0] MODE_STBY = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [6:0] WAKE_HALT_MASK = 7'h07;

  typedef enum logic [2:0] {
    PMRS_ST_RESET = 3'b000,
    PMRS_ST_PWRUP = 3'b001,
    PMRS_ST_OST = 3'b010,
    PMRS_ST_RUN = 3'b011,
    PMRS_ST_STBY = 3'b100,
    PMRS_ST_HALT = 3'b101,
    PMRS_ST_WAKE = 3'b110
  } pmrs_state_t;
endpackage

//--- pmrs_delay_timer.sv
// down-counting delay timer that pulses done when a loaded count runs out
`timescale 1ns/1ps
module pmrs_delay_timer (
  input logic aclk,
  input logic aresetn,
  input logic load,
  input logic [25:0] load_val,
  output logic done
);
  logic [25:0] cnt_q;
  logic done_q;

  // done lands n edges after the edge that loads n
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 26'h000_0001) && !load;
      if (load) begin
        cnt_q <= load_val;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 26'h000_0001;
      end
    end
  end

  assign done = done_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_done_after_one: assert property (done_q |-> $past(cnt_q) == 26'h000_0001)
    else $error("timer done without count reaching one");
endmodule // pmrs_delay_timer

//--- pmrs_top.sv
// power mode control and reset sequencing behind an AXI4-Lite register port
//
// How it works
// - any of supply rise, low supply, reset pin low or watchdog timeout forces reset.
// - reset reloads control registers; configuration keeps its contents, flag bits follow the cause.
// - power-on or low supply reset sets timeout and powerdown flags to one.
// - pin reset outside halt leaves both flags as they were.
// - pin reset during halt sets both flags to one.
// - watchdog reset outside halt clears timeout flag, sets powerdown flag.
// - watchdog reset during halt clears both flags.
// - halt command sets timeout, clears powerdown; watchdog kick sets both.
// - after sources release, always wait the power-up period first.
// - power-up period picked by three config bits: 140us to 288ms.
// - after a 140us power-up wait, one more settle cycle.
// - after longer power-up waits, sixteen more settle cycles.
// - normal runs both oscillators; slow mode lets fast oscillator stop.
// - standby stops execution, slow oscillator runs, many wake sources.
// - halt stops everything; only watchdog, port change, external interrupt wake.
// - mode field 10b enters standby; 01b or halt command enters halt.
// - wake-up resumes normal or slow according to fast oscillator select.
// - halt wake waits 512 cycles with crystal, else 16; standby none.
// - halt entry clears powerdown, sets timeout, clears watchdog count.
`timescale 1ns/1ps
module pmrs_top #(
  parameter logic [25:0] PWRUP_CYC_0 = pmrs_pkg::PWRUP_CYC_0,
  parameter logic [25:0] PWRUP_CYC_1 = pmrs_pkg::PWRUP_CYC_1,
  parameter logic [25:0] PWRUP_CYC_2 = pmrs_pkg::PWRUP_CYC_2,
  parameter logic [25:0] PWRUP_CYC_3 = pmrs_pkg::PWRUP_CYC_3,
  parameter logic [25:0] PWRUP_CYC_4 = pmrs_pkg::PWRUP_CYC_4
) (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  input logic power_rise,
  input logic low_supply_reset,
  input logic ext_reset_n,
  input logic watchdog_timeout,
  input logic [6:0] wake_event,
  output logic fast_osc_en,
  output logic slow_osc_en,
  output logic exec_en,
  output logic timer_on,
  output logic modules_on,
  output logic watchdog_clear,
  output logic sys_reset_n
);
  pmrs_pkg::pmrs_state_t st_q, st_d;
  logic [10:0] sync1_q, sync2_q;
  logic por_s, lvr_s, ext_s, wdt_s, any_src, src_new, halted;
  logic [6:0] wake_s;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_word;
  logic wr_fire, ar_fire, wr_en, running;
  logic sel_q, stop_q;
  logic [1:0] mode_req_q;
  logic [4:0] cfg_q;
  logic to_q, pd_q;
  logic halt_cmd, kick_cmd, halt_req, halt_enter;
  logic tmr_load, tmr_done;
  logic [25:0] tmr_val;
  logic fast_q, slow_q, exec_q, timer_q, mod_q, wclr_q, sysrst_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic is_halted(input pmrs_pkg::pmrs_state_t s);
    return (s == pmrs_pkg::PMRS_ST_HALT) || (s == pmrs_pkg::PMRS_ST_WAKE);
  endfunction

  // sources and wake events come from other domains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {power_rise, low_supply_reset, ext_reset_n, watchdog_timeout, wake_event};
      sync2_q <= sync1_q;
    end
  end

  assign por_s = sync2_q[10];
  assign lvr_s = sync2_q[9];
  assign ext_s = !sync2_q[8];
  assign wdt_s = sync2_q[7];
  assign wake_s = sync2_q[6:0];
  assign any_src = por_s || lvr_s || ext_s || wdt_s;
  assign src_new = any_src && (st_q != pmrs_pkg::PMRS_ST_RESET);
  assign halted = is_halted(st_q);
  assign running = (st_q == pmrs_pkg::PMRS_ST_RUN);

  // write channel: address and data taken together, one write in flight
  assign wr_fire = awvalid && wvalid && !awready_q && !bvalid_q;
  assign wr_en = wr_fire && wstrb[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= pmrs_pkg::RESP_OKAY;
    end else begin
      awready_q <= wr_fire;
      wready_q <= wr_fire;
      if (wr_fire) begin
        if (hit(awaddr, pmrs_pkg::ADDR_CTRL) || hit(awaddr, pmrs_pkg::ADDR_CMD) ||
            hit(awaddr, pmrs_pkg::ADDR_STAT) || hit(awaddr, pmrs_pkg::ADDR_CFG)) begin
          bresp_q <= pmrs_pkg::RESP_OKAY;
        end else begin
          bresp_q <= pmrs_pkg::RESP_SLVERR;
        end
      end
      if (awready_q) begin
        bvalid_q <= 1'b1;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel
  assign ar_fire = arvalid && !arready_q && !rvalid_q;

  always_comb begin
    rd_word = '0;
    if (hit(araddr, pmrs_pkg::ADDR_CTRL)) begin
      rd_word = {28'h000_0000, mode_req_q, stop_q, sel_q};
    end else if (hit(araddr, pmrs_pkg::ADDR_STAT)) begin
      rd_word = {27'h000_0000, st_q, pd_q, to_q};
    end else if (hit(araddr, pmrs_pkg::ADDR_CFG)) begin
      rd_word = {27'h000_0000, cfg_q};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= pmrs_pkg::RESP_OKAY;
    end else begin
      arready_q <= ar_fire;
      if (ar_fire) begin
        rdata_q <= rd_word;
        if (hit(araddr, pmrs_pkg::ADDR_CTRL) || hit(araddr, pmrs_pkg::ADDR_CMD) ||
            hit(araddr, pmrs_pkg::ADDR_STAT) || hit(araddr, pmrs_pkg::ADDR_CFG)) begin
          rresp_q <= pmrs_pkg::RESP_OKAY;
        end else begin
          rresp_q <= pmrs_pkg::RESP_SLVERR;
        end
      end
      if (arready_q) begin
        rvalid_q <= 1'b1;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // commands only act while the core executes
  assign halt_cmd = wr_en && running && hit(awaddr, pmrs_pkg::ADDR_CMD) &&
                    wdata[pmrs_pkg::CMD_HALT_BIT];
  assign kick_cmd = wr_en && running && hit(awaddr, pmrs_pkg::ADDR_CMD) &&
                    wdata[pmrs_pkg::CMD_KICK_BIT];
  assign halt_req = halt_cmd || (mode_req_q == pmrs_pkg::MODE_HALT);
  assign halt_enter = running && halt_req && !any_src;

  // control register: reloaded by any reset event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // constant here: cfg_q is itself being reset in this same cycle
      sel_q <= pmrs_pkg::CFG_RST[pmrs_pkg::CFG_FAST_BIT];
      stop_q <= 1'b0;
      mode_req_q <= pmrs_pkg::MODE_NONE;
    end else if (st_q == pmrs_pkg::PMRS_ST_RESET || any_src) begin
      sel_q <= cfg_q[pmrs_pkg::CFG_FAST_BIT];
      stop_q <= 1'b0;
      mode_req_q <= pmrs_pkg::MODE_NONE;
    end else if (running && st_d != pmrs_pkg::PMRS_ST_RUN) begin
      mode_req_q <= pmrs_pkg::MODE_NONE;
    end else if (wr_en && running && hit(awaddr, pmrs_pkg::ADDR_CTRL)) begin
      sel_q <= wdata[pmrs_pkg::CTRL_SEL_BIT];
      stop_q <= wdata[pmrs_pkg::CTRL_STOP_BIT];
      mode_req_q <= wdata[pmrs_pkg::CTRL_MODE_LSB +: 2];
    end
  end

  // configuration word survives reset events, only aresetn restores it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= pmrs_pkg::CFG_RST;
    end else if (wr_en && hit(awaddr, pmrs_pkg::ADDR_CFG)) begin
      cfg_q <= wdata[4:0];
    end
  end

  // timeout and powerdown flags by cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (por_s || lvr_s) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (src_new && wdt_s) begin
      to_q <= 1'b0;
      pd_q <= !halted;
    end else if (src_new && ext_s && halted) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (halt_enter) begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end else if (kick_cmd && !any_src) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end
    // a pin reset outside halt falls through and keeps both flags
  end

  function automatic logic [25:0] pwrup_cycles(input logic [2:0] s);
    case (s)
      3'h0: return PWRUP_CYC_0;
      3'h1: return PWRUP_CYC_1;
      3'h2: return PWRUP_CYC_2;
      3'h3: return PWRUP_CYC_3;
      default: return PWRUP_CYC_4;
    endcase
  endfunction

  always_comb begin
    st_d = st_q;
    if (any_src) begin
      st_d = pmrs_pkg::PMRS_ST_RESET;
    end else begin
      case (st_q)
        pmrs_pkg::PMRS_ST_RESET: st_d = pmrs_pkg::PMRS_ST_PWRUP;
        pmrs_pkg::PMRS_ST_PWRUP: if (tmr_done) st_d = pmrs_pkg::PMRS_ST_OST;
        pmrs_pkg::PMRS_ST_OST: if (tmr_done) st_d = pmrs_pkg::PMRS_ST_RUN;
        pmrs_pkg::PMRS_ST_RUN: begin
          if (halt_req) begin
            st_d = pmrs_pkg::PMRS_ST_HALT;
          end else if (mode_req_q == pmrs_pkg::MODE_STBY) begin
            st_d = pmrs_pkg::PMRS_ST_STBY;
          end
        end
        pmrs_pkg::PMRS_ST_STBY: if (|wake_s) st_d = pmrs_pkg::PMRS_ST_RUN;
        pmrs_pkg::PMRS_ST_HALT: begin
          if (|(wake_s & pmrs_pkg::WAKE_HALT_MASK)) st_d = pmrs_pkg::PMRS_ST_WAKE;
        end
        pmrs_pkg::PMRS_ST_WAKE: if (tmr_done) st_d = pmrs_pkg::PMRS_ST_RUN;
        default: st_d = pmrs_pkg::PMRS_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= pmrs_pkg::PMRS_ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // one timer serves power-up, settle and halt wake waits
  always_comb begin
    tmr_load = 1'b0;
    tmr_val = '0;
    if (!any_src) begin
      case (st_q)
        pmrs_pkg::PMRS_ST_RESET: begin
          tmr_load = 1'b1;
          tmr_val = pwrup_cycles(cfg_q[2:0]);
        end
        pmrs_pkg::PMRS_ST_PWRUP: begin
          tmr_load = tmr_done;
          tmr_val = (cfg_q[2:0] == 3'h0) ? pmrs_pkg::OST_SHORT_CYC
                                         : pmrs_pkg::OST_LONG_CYC;
        end
        pmrs_pkg::PMRS_ST_HALT: begin
          tmr_load = |(wake_s & pmrs_pkg::WAKE_HALT_MASK);
          tmr_val = cfg_q[pmrs_pkg::CFG_XTAL_BIT] ? pmrs_pkg::WAKE_XTAL_CYC
                                                  : pmrs_pkg::WAKE_RC_CYC;
        end
        default: tmr_load = 1'b0;
      endcase
    end
  end

  pmrs_delay_timer pmrs_delay_timer_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // gating outputs follow the state one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_q <= 1'b1;
      slow_q <= 1'b1;
      exec_q <= 1'b0;
      timer_q <= 1'b0;
      mod_q <= 1'b0;
      sysrst_q <= 1'b0;
    end else begin
      sysrst_q <= (st_q != pmrs_pkg::PMRS_ST_RESET);
      case (st_q)
        pmrs_pkg::PMRS_ST_RUN, pmrs_pkg::PMRS_ST_STBY: begin
          // stop only bites in slow mode, so normal mode keeps its clock
          fast_q <= sel_q || !stop_q;
          slow_q <= 1'b1;
          exec_q <= running;
          timer_q <= 1'b1;
          mod_q <= 1'b1;
        end
        pmrs_pkg::PMRS_ST_HALT: begin
          fast_q <= 1'b0;
          slow_q <= 1'b0;
          exec_q <= 1'b0;
          timer_q <= 1'b0;
          mod_q <= 1'b0;
        end
        default: begin
          fast_q <= 1'b1;
          slow_q <= 1'b1;
          exec_q <= 1'b0;
          timer_q <= 1'b0;
          mod_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wclr_q <= 1'b0;
    end else begin
      wclr_q <= halt_enter || (kick_cmd && !any_src);
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign fast_osc_en = fast_q;
  assign slow_osc_en = slow_q;
  assign exec_en = exec_q;
  assign timer_on = timer_q;
  assign modules_on = mod_q;
  assign watchdog_clear = wclr_q;
  assign sys_reset_n = sysrst_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_short_settle;
    (st_q == pmrs_pkg::PMRS_ST_PWRUP && tmr_done && cfg_q[2:0] == 3'h0 && !any_src)
      ##1 (!any_src)[*2];
  endsequence

  a_reset_holds: assert property (any_src |-> ##2 !exec_en)
    else $error("execution not stopped under reset");
  a_por_flags: assert property ((por_s || lvr_s) |=> to_q && pd_q)
    else $error("power or supply reset did not set flags");
  a_ext_keep: assert property (src_new && ext_s && !wdt_s && !por_s && !lvr_s && !halted
    |=> $stable({to_q, pd_q}))
    else $error("pin reset outside halt changed flags");
  a_ext_halt: assert property (src_new && ext_s && !wdt_s && !por_s && !lvr_s && halted
    |=> to_q && pd_q)
    else $error("pin reset in halt did not set flags");
  a_wdt_run: assert property (src_new && wdt_s && !por_s && !lvr_s && !halted
    |=> !to_q && pd_q)
    else $error("watchdog reset outside halt flags wrong");
  a_wdt_halt: assert property (src_new && wdt_s && !por_s && !lvr_s && halted
    |=> !to_q && !pd_q)
    else $error("watchdog reset in halt flags wrong");
  a_halt_entry: assert property (halt_enter |=> to_q && !pd_q && watchdog_clear
    && st_q == pmrs_pkg::PMRS_ST_HALT)
    else $error("halt entry effects missing");
  a_short_settle: assert property (s_short_settle |=> st_q == pmrs_pkg::PMRS_ST_RUN)
    else $error("short settle wait not one cycle");
  a_halt_dark: assert property (st_q == pmrs_pkg::PMRS_ST_HALT |=> !fast_osc_en
    && !slow_osc_en && !timer_on)
    else $error("clocks still running in halt");
endmodule // pmrs_top

//--- pmrs_top_tb_top.sv
// self-checking testbench for the power mode and reset sequencer
`timescale 1ns/1ps
module pmrs_top_tb_top;
  localparam int P[5] = '{20, 30, 40, 50, 60};
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic power_rise = 0, low_supply_reset = 0, ext_reset_n = 1, watchdog_timeout = 0;
  logic [6:0] wake_event = 0;
  logic fast_osc_en, slow_osc_en, exec_en, timer_on, modules_on, watchdog_clear, sys_reset_n;
  int n_errors = 0, n_tests = 0, n_wdc = 0;
  logic [31:0] v;
  logic [1:0] r;

  pmrs_top #(.PWRUP_CYC_0(26'h000_0014), .PWRUP_CYC_1(26'h000_001e), .PWRUP_CYC_2(26'h000_0028),
    .PWRUP_CYC_3(26'h000_0032), .PWRUP_CYC_4(26'h000_003c)) pmrs_top_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .power_rise(power_rise),
    .low_supply_reset(low_supply_reset), .ext_reset_n(ext_reset_n),
    .watchdog_timeout(watchdog_timeout), .wake_event(wake_event), .fast_osc_en(fast_osc_en),
    .slow_osc_en(slow_osc_en), .exec_en(exec_en), .timer_on(timer_on), .modules_on(modules_on),
    .watchdog_clear(watchdog_clear), .sys_reset_n(sys_reset_n));

  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (watchdog_clear === 1'b1) n_wdc <= n_wdc + 1;
  end

  task print_verdict;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task hang(input string m);
    n_errors++;
    $display("CHECK FAILED t=%0t timeout %s", $time, m);
    print_verdict();
  endtask

  // master holds each channel until its own ready edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 0;
        break;
      end
    end
    if (i == 200) hang("write");
  endtask

  task rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 0;
      if (rvalid === 1'b1) begin
        v = rdata;
        r = rresp;
        rready <= 0;
        break;
      end
    end
    if (i == 200) hang("read");
  endtask

  task wait_run(output int n);
    n = 0;
    while (exec_en !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n > 3000) hang("run");
    end
  endtask

  // k: 0 supply rise, 1 low supply, 2 pin, 3 watchdog
  task src_pulse(input int k, output int n);
    @(posedge aclk);
    case (k)
      0: power_rise <= 1;
      1: low_supply_reset <= 1;
      2: ext_reset_n <= 0;
      default: watchdog_timeout <= 1;
    endcase
    repeat (6) @(posedge aclk);
    chk(sys_reset_n, 0, "reset out");
    chk(exec_en, 0, "exec held");
    power_rise <= 0;
    low_supply_reset <= 0;
    ext_reset_n <= 1;
    watchdog_timeout <= 0;
    wait_run(n);
  endtask

  task flags_after(input int k, input logic [1:0] exp, input string m);
    int n;
    src_pulse(k, n);
    rd(pmrs_pkg::ADDR_STAT);
    chk(v[1:0], exp, m);
  endtask

  task t_defaults;
    rd(pmrs_pkg::ADDR_CFG);
    chk(v, 32'h0000_0010, "cfg reset");
    rd(pmrs_pkg::ADDR_CTRL);
    chk(v, 32'h0000_0001, "ctrl reset");
    rd(pmrs_pkg::ADDR_STAT);
    chk(v, 32'h0000_000f, "stat after power up");
    chk({fast_osc_en, slow_osc_en, exec_en}, 3'h7, "normal outputs");
  endtask

  task t_flags;
    int c;
    flags_after(1, 2'h3, "low supply flags");
    flags_after(3, 2'h2, "watchdog flags");
    flags_after(2, 2'h2, "pin flags kept");
    c = n_wdc;
    wr(pmrs_pkg::ADDR_CMD, 32'h0000_0002);
    repeat (2) @(posedge aclk);
    rd(pmrs_pkg::ADDR_STAT);
    chk(v[1:0], 2'h3, "kick flags");
    chk(n_wdc - c, 1, "kick clears watchdog");
    wr(pmrs_pkg::ADDR_CMD, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    rd(pmrs_pkg::ADDR_STAT);
    chk(v[4:0], 5'h15, "halt flags and state");
    chk(n_wdc - c, 2, "halt clears watchdog");
    chk({fast_osc_en, slow_osc_en, exec_en, timer_on, modules_on}, 5'h0, "halt off");
    flags_after(3, 2'h0, "watchdog in halt");
    wr(pmrs_pkg::ADDR_CMD, 32'h0000_0001);
    flags_after(2, 2'h3, "pin in halt");
    flags_after(3, 2'h2, "watchdog again");
    flags_after(0, 2'h3, "supply rise flags");
  endtask

  task t_modes;
    int n;
    wr(pmrs_pkg::ADDR_CTRL, 32'h0000_0009);
    repeat (3) @(posedge aclk);
    rd(pmrs_pkg::ADDR_STAT);
    chk(v[4:2], 3'h4, "standby state");
    chk({exec_en, slow_osc_en, timer_on, modules_on}, 4'h7, "standby outputs");
    wake_event <= 7'h40;
    wait_run(n);
    chk(n, 5, "standby wake no wait");
    wake_event <= 7'h00;
    rd(pmrs_pkg::ADDR_CTRL);
    chk(v, 32'h0000_0001, "mode self clear");
    wr(pmrs_pkg::ADDR_CTRL, 32'h0000_0000);
    wr(pmrs_pkg::ADDR_CTRL, 32'h0000_0002);
    repeat (3) @(posedge aclk);
    chk({fast_osc_en, slow_osc_en, exec_en}, 3'h3, "slow with fast stopped");
    wr(pmrs_pkg::ADDR_CTRL, 32'h0000_000a);
    repeat (3) @(posedge aclk);
    wake_event <= 7'h08;
    wait_run(n);
    wake_event <= 7'h00;
    repeat (2) @(posedge aclk);
    chk(fast_osc_en, 0, "resume slow");
    wr(pmrs_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk(fast_osc_en, 1, "back to normal");
  endtask

  task halt_wake(input logic [6:0] w, output int n);
    wr(pmrs_pkg::ADDR_CTRL, 32'h0000_0005);
    repeat (4) @(posedge aclk);
    wake_event <= w;
    wait_run(n);
    wake_event <= 7'h00;
  endtask

  task t_halt;
    int a;
    int b;
    wr(pmrs_pkg::ADDR_CTRL, 32'h0000_0005);
    wake_event <= 7'h78;
    repeat (10) @(posedge aclk);
    rd(pmrs_pkg::ADDR_STAT);
    chk(v[4:0], 5'h15, "halt ignores other wakes");
    wake_event <= 7'h04;
    wait_run(a);
    wake_event <= 7'h00;
    halt_wake(7'h02, a);
    wr(pmrs_pkg::ADDR_CFG, 32'h0000_0018);
    halt_wake(7'h01, b);
    chk(b - a, 496, "halt wake crystal wait");
    wr(pmrs_pkg::ADDR_CFG, 32'h0000_0010);
  endtask

  task t_pwrup;
    int n0;
    int n;
    int s;
    int e;
    for (s = 0; s < 8; s++) begin
      wr(pmrs_pkg::ADDR_CFG, 32'h0000_0010 | s);
      src_pulse(1, n);
      if (s == 0) n0 = n;
      e = (s > 4 ? P[4] : P[s]) - P[0] + (s > 0 ? 15 : 0);
      chk(n - n0, e, "power-up length");
    end
    wr(pmrs_pkg::ADDR_CFG, 32'h0000_0000);
    src_pulse(2, n);
    rd(pmrs_pkg::ADDR_CTRL);
    chk(v, 32'h0000_0000, "ctrl reload from cfg");
    rd(pmrs_pkg::ADDR_CFG);
    chk(v, 32'h0000_0000, "cfg kept over reset");
    wr(pmrs_pkg::ADDR_CFG, 32'h0000_0010);
  endtask

  task t_bus;
    int n;
    rd(8'h10);
    chk(v, 32'h0000_0000, "unmapped read data");
    chk(r, pmrs_pkg::RESP_SLVERR, "unmapped read resp");
    wr(8'h20, 32'h0000_00ff);
    chk(r, pmrs_pkg::RESP_SLVERR, "unmapped write");
    rd(pmrs_pkg::ADDR_CMD);
    chk(v, 32'h0000_0000, "cmd reads zero");
    chk(r, pmrs_pkg::RESP_OKAY, "cmd read resp");
    // low byte strobe off: answered, but nothing lands
    wstrb <= 4'h0;
    wr(pmrs_pkg::ADDR_CFG, 32'h0000_0007);
    wstrb <= 4'hf;
    chk(r, pmrs_pkg::RESP_OKAY, "masked write resp");
    rd(pmrs_pkg::ADDR_CFG);
    chk(v, 32'h0000_0010, "masked write ignored");
    // mode requests with a source held and during the power-up wait are dropped
    @(posedge aclk);
    low_supply_reset <= 1;
    repeat (6) @(posedge aclk);
    wr(pmrs_pkg::ADDR_CTRL, 32'h0000_0009);
    low_supply_reset <= 0;
    repeat (3) @(posedge aclk);
    wr(pmrs_pkg::ADDR_CTRL, 32'h0000_0009);
    wait_run(n);
    rd(pmrs_pkg::ADDR_STAT);
    chk(v[4:2], 3'h3, "mode ignored in reset");
    rd(pmrs_pkg::ADDR_CTRL);
    chk(v, 32'h0000_0001, "ctrl untouched in reset");
  endtask

  initial begin
    int n;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    wait_run(n);
    t_defaults();
    t_flags();
    t_modes();
    t_halt();
    t_pwrup();
    t_bus();
    print_verdict();
  end
endmodule // pmrs_top_tb_top
